// ===== rtl/delay_if.sv
`timescale 1ns/1ps
`default_nettype none
// Request and completion between the supervisor and its delay timer.
interface delay_if;
  logic start; // One-cycle pulse that (re)starts the delay.
  logic abort; // One-cycle pulse that cancels a running delay.
  logic [7:0] units; // Delay length in delay units, taken with start.
  logic done; // One-cycle pulse when the delay has expired.
  modport ctrl (output start, output abort, output units, input done);
  modport timer (input start, input abort, input units, output done);
endinterface : delay_if
`default_nettype wire

// ===== rtl/delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Length of one delay unit in clock cycles, zero counts as one.
  input wire logic [15:0] unit_cycles,
  // Request and completion.
  delay_if.timer req
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] tick_reg; // Cycles counted inside the current unit.
  logic [15:0] tick_next;
  logic [7:0] left_reg; // Units still to run.
  logic [7:0] left_next;
  logic busy_reg; // A delay is running.
  logic busy_next;
  logic unit_end; // Last cycle of a delay unit.

  assign unit_end = ({16'h0000, tick_reg} + 32'h0000_0001) >= {16'h0000, unit_cycles};
  // Expiry shows in the last cycle, keeping spacing exact.
  assign req.done = busy_reg && unit_end && (left_reg <= 8'h01);

  // A start always wins, so a new delay replaces a running one.
  always_comb
  begin
    tick_next = tick_reg;
    left_next = left_reg;
    busy_next = busy_reg;
    if (req.start)
    begin
      tick_next = 16'h0000;
      left_next = req.units;
      busy_next = 1'b1;
    end
    else if (req.abort)
    begin
      busy_next = 1'b0;
    end
    else if (busy_reg)
    begin
      if (unit_end)
      begin
        tick_next = 16'h0000;
        if (left_reg <= 8'h01)
        begin
          busy_next = 1'b0;
        end
        else
        begin
          left_next = left_reg - 8'h01;
        end
      end
      else
      begin
        tick_next = tick_reg + 16'h0001;
      end
    end
  end

  // Registers of the timer.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      tick_reg <= 16'h0000;
      left_reg <= 8'h00;
      busy_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
      left_reg <= left_next;
      busy_reg <= busy_next;
    end
  end

endmodule : delay_timer
`default_nettype wire

// ===== rtl/dummy_end_marker_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== rtl/output_low_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module output_low_supervisor (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Decoded command port from the bus front end.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_error,
  // Measured output voltage and delay unit length.
  input wire logic [15:0] vout_level,
  input wire logic [15:0] unit_cycles,
  // Control and clear events.
  input wire logic on_command,
  input wire logic bias_ok,
  input wire logic other_fault_off,
  input wire logic clear_faults,
  input wire logic clear_low_fault_bit,
  // Output control and status.
  output logic output_enable,
  output logic low_warning_status,
  output logic low_fault_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [15:0] output_low_warning_threshold_reg; // Warning threshold.
  logic [15:0] output_low_warning_threshold_next;
  logic [15:0] output_low_fault_threshold_reg; // Fault threshold.
  logic [15:0] output_low_fault_threshold_next;
  logic [7:0] output_low_fault_action_reg; // Response, retries and delay.
  logic [7:0] output_low_fault_action_next;
  logic rsp_valid_reg; // Answer strobe.
  logic rsp_valid_next;
  logic [15:0] rsp_data_reg; // Read data.
  logic [15:0] rsp_data_next;
  logic rsp_error_reg; // Unsupported command code.
  logic rsp_error_next;

  // Each write lands in the addressed register; reads answer one cycle later.
  always_comb
  begin
    output_low_warning_threshold_next = output_low_warning_threshold_reg;
    output_low_fault_threshold_next = output_low_fault_threshold_reg;
    output_low_fault_action_next = output_low_fault_action_reg;
    rsp_valid_next = cmd_valid;
    rsp_data_next = 16'h0000;
    rsp_error_next = 1'b0;
    if (cmd_valid)
    begin
      case (cmd_code)
        uv_pkg::CMD_WARN_LIMIT:
        begin
          if (cmd_write)
          begin
            output_low_warning_threshold_next = cmd_wdata;
          end
          rsp_data_next = output_low_warning_threshold_reg;
        end
        uv_pkg::CMD_FAULT_LIMIT:
        begin
          if (cmd_write)
          begin
            output_low_fault_threshold_next = cmd_wdata;
          end
          rsp_data_next = output_low_fault_threshold_reg;
        end
        uv_pkg::CMD_FAULT_ACTION:
        begin
          if (cmd_write)
          begin
            output_low_fault_action_next = cmd_wdata[7:0];
          end
          rsp_data_next = {8'h00, output_low_fault_action_reg};
        end
        default:
        begin
          // Unknown codes store nothing and read as zero.
          rsp_error_next = 1'b1;
        end
      endcase
    end
  end

  // Registers of the register file.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      output_low_warning_threshold_reg <= uv_pkg::WARN_LIMIT_RESET;
      output_low_fault_threshold_reg <= uv_pkg::FAULT_LIMIT_RESET;
      output_low_fault_action_reg <= uv_pkg::FAULT_ACTION_RESET;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
      rsp_error_reg <= 1'b0;
    end
    else
    begin
      output_low_warning_threshold_reg <= output_low_warning_threshold_next;
      output_low_fault_threshold_reg <= output_low_fault_threshold_next;
      output_low_fault_action_reg <= output_low_fault_action_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_error_reg <= rsp_error_next;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_error = rsp_error_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Comparisons and event decode.
  logic [1:0] resp_mode; // Selected response.
  logic [2:0] retry_set; // Selected retry setting.
  logic [7:0] delay_len; // Delay length in units.
  logic below_fault; // Output is under the fault threshold.
  logic below_warn; // Output is under the warning threshold.
  logic stop_req; // Output must be off regardless of the fault.
  logic on_prev_reg; // Previous on command, for the off-then-on edge.
  logic clear_evt; // Any event that removes a latched fault.

  assign resp_mode = output_low_fault_action_reg[uv_pkg::ACT_RESP_HI:uv_pkg::ACT_RESP_LO];
  assign retry_set = output_low_fault_action_reg[uv_pkg::ACT_RETRY_HI:uv_pkg::ACT_RETRY_LO];
  assign delay_len = uv_pkg::delay_units(
    output_low_fault_action_reg[uv_pkg::ACT_DELAY_HI:uv_pkg::ACT_DELAY_LO]);
  assign below_fault = vout_level < output_low_fault_threshold_reg;
  assign below_warn = vout_level < output_low_warning_threshold_reg;
  assign stop_req = !on_command || !bias_ok || other_fault_off;
  assign clear_evt = clear_low_fault_bit || clear_faults || !bias_ok
    || (on_command && !on_prev_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Delay timer shared by the delayed response and the retry spacing.
  delay_if tmr ();

  delay_timer u_delay_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .unit_cycles(unit_cycles),
    .req(tmr.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault response sequencer.
  uv_pkg::uv_state_t state_reg; // Current state.
  uv_pkg::uv_state_t state_next;
  logic [2:0] tries_reg; // Restart attempts still allowed.
  logic [2:0] tries_next;
  logic out_en_reg; // Registered output enable.
  logic out_en_next;
  logic start_req; // Timer start pulse.
  logic abort_req; // Timer abort pulse.

  assign tmr.start = start_req;
  assign tmr.abort = abort_req;
  assign tmr.units = delay_len;

  // Next state; a stop request beats every fault action.
  always_comb
  begin
    state_next = state_reg;
    tries_next = tries_reg;
    start_req = 1'b0;
    abort_req = 1'b0;
    if (stop_req && state_reg != uv_pkg::ST_OFF)
    begin
      // Commanded off, bias gone or another fault: retrying ends here.
      state_next = uv_pkg::ST_OFF;
      abort_req = 1'b1;
    end
    else
    begin
      case (state_reg)
        uv_pkg::ST_OFF:
        begin
          // Leaving the off state is the off-then-on clear as well.
          if (!stop_req)
          begin
            state_next = uv_pkg::ST_RUN;
          end
        end
        uv_pkg::ST_RUN:
        begin
          if (below_fault)
          begin
            case (resp_mode)
              uv_pkg::RESP_IGNORE:
              begin
                // Keep running without interruption.
                state_next = uv_pkg::ST_RUN;
              end
              uv_pkg::RESP_DELAYED:
              begin
                state_next = uv_pkg::ST_DELAY;
                start_req = 1'b1;
              end
              uv_pkg::RESP_SHUTDOWN:
              begin
                // Output drops now; retry setting decides what follows.
                tries_next = retry_set;
                start_req = retry_set != uv_pkg::RETRY_NONE;
                state_next = (retry_set == uv_pkg::RETRY_NONE) ? uv_pkg::ST_LATCH : uv_pkg::ST_WAIT;
              end
              uv_pkg::RESP_HOLD:
              begin
                state_next = uv_pkg::ST_HOLD;
              end
              default:
              begin
                state_next = uv_pkg::ST_RUN;
              end
            endcase
          end
        end
        uv_pkg::ST_DELAY:
        begin
          // Output stays on; at expiry a persisting fault takes the retry path.
          if (tmr.done)
          begin
            if (below_fault)
            begin
              tries_next = retry_set;
              start_req = retry_set != uv_pkg::RETRY_NONE;
              state_next = (retry_set == uv_pkg::RETRY_NONE) ? uv_pkg::ST_LATCH : uv_pkg::ST_WAIT;
            end
            else
            begin
              state_next = uv_pkg::ST_RUN;
            end
          end
        end
        uv_pkg::ST_WAIT:
        begin
          // Output off for one interval, then the first attempt begins.
          if (tmr.done)
          begin
            state_next = uv_pkg::ST_RETRY;
            start_req = 1'b1;
            if (tries_reg != uv_pkg::RETRY_FOREVER)
            begin
              tries_next = tries_reg - 3'h1;
            end
          end
        end
        uv_pkg::ST_RETRY:
        begin
          // An attempt lasts one interval; the next starts right at its end.
          if (tmr.done)
          begin
            if (!below_fault)
            begin
              state_next = uv_pkg::ST_RUN;
            end
            else if (tries_reg == uv_pkg::RETRY_FOREVER)
            begin
              start_req = 1'b1;
            end
            else if (tries_reg != 3'h0)
            begin
              start_req = 1'b1;
              tries_next = tries_reg - 3'h1;
            end
            else
            begin
              // Last allowed attempt failed: stay off until cleared.
              state_next = uv_pkg::ST_LATCH;
            end
          end
        end
        uv_pkg::ST_LATCH:
        begin
          if (clear_evt)
          begin
            state_next = uv_pkg::ST_RUN;
          end
        end
        uv_pkg::ST_HOLD:
        begin
          // Resume on its own once the output is no longer low.
          if (!below_fault)
          begin
            state_next = uv_pkg::ST_RUN;
          end
        end
        default:
        begin
          state_next = uv_pkg::ST_OFF;
          abort_req = 1'b1;
        end
      endcase
    end
    out_en_next = (state_next == uv_pkg::ST_RUN) || (state_next == uv_pkg::ST_DELAY)
      || (state_next == uv_pkg::ST_RETRY);
  end

  // Registers of the sequencer.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= uv_pkg::ST_OFF;
      tries_reg <= 3'h0;
      out_en_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tries_reg <= tries_next;
      out_en_reg <= out_en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a new low reading in the clearing cycle wins.
  logic warn_reg; // Warning status.
  logic warn_next;
  logic fault_reg; // Fault status.
  logic fault_next;

  always_comb
  begin
    warn_next = (out_en_reg && below_warn) || (warn_reg && !clear_evt);
    fault_next = (out_en_reg && below_fault) || (fault_reg && !clear_evt);
  end

  // Registers of the status flags and edge detector.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      warn_reg <= 1'b0;
      fault_reg <= 1'b0;
      on_prev_reg <= 1'b0;
    end
    else
    begin
      warn_reg <= warn_next;
      fault_reg <= fault_next;
      on_prev_reg <= on_command;
    end
  end

  assign output_enable = out_en_reg;
  assign low_warning_status = warn_reg;
  assign low_fault_status = fault_reg;

endmodule : output_low_supervisor
`default_nettype wire

// ===== rtl/uv_pkg.sv
package uv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes of the supervised registers.
  localparam logic [7:0] CMD_WARN_LIMIT = 8'h43;
  localparam logic [7:0] CMD_FAULT_LIMIT = 8'h44;
  localparam logic [7:0] CMD_FAULT_ACTION = 8'h45;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the fault action byte.
  localparam int ACT_RESP_HI = 7;
  localparam int ACT_RESP_LO = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the registers.
  localparam logic [15:0] WARN_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] FAULT_LIMIT_RESET = 16'h0000;
  localparam logic [7:0] FAULT_ACTION_RESET = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // Response field encodings.
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_HOLD = 2'h3;

  // Retry field encodings with a special meaning.
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor states, one-hot.
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_RUN = 7'h02,
    ST_DELAY = 7'h04,
    ST_WAIT = 7'h08,
    ST_RETRY = 7'h10,
    ST_LATCH = 7'h20,
    ST_HOLD = 7'h40
  } uv_state_t;

  // Number of delay units for a 3-bit delay code.
  function automatic logic [7:0] delay_units(input logic [2:0] code);
    logic [7:0] units;
    units = 8'h01;
    case (code)
      3'h0: units = 8'h01;
      3'h1: units = 8'h01;
      3'h2: units = 8'h02;
      3'h3: units = 8'h08;
      3'h4: units = 8'h10;
      3'h5: units = 8'h20;
      3'h6: units = 8'h40;
      3'h7: units = 8'h80;
      default: units = 8'h01;
    endcase
    return units;
  endfunction : delay_units

endpackage : uv_pkg

// ===== testbench/test_output_low_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the output low voltage supervisor.
module test_output_low_supervisor;
  logic sys_clk, reset_n, cmd_valid, cmd_write, rsp_valid, rsp_error, on_command, bias_ok;
  logic other_fault_off, clear_faults, clear_low_fault_bit, output_enable, low_warning_status;
  logic low_fault_status, er, ok;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data, vout_level, unit_cycles, rd;
  int n_errors, compares, cycles, n;
  int units[8] = '{1, 1, 2, 8, 16, 32, 64, 128}; // Delay units per code.
  uv_host uv_host_i (.*);
  output_low_supervisor output_low_supervisor_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns, and a cycle ceiling against hangs.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("timeout after %0d cycles", cycles);
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  task automatic chk_val(input string name, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask : chk_val
  task automatic chk_flag(input string name, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", name, e, g);
    end
  endtask : chk_flag
  task automatic chk_time(input string name, input int e, input int g, input int tol);
    compares++;
    if (g < e - tol || g > e + tol)
    begin
      n_errors++;
      $display("unexpected %s: expected %0d, seen %0d", name, e, g);
    end
  endtask : chk_time
  // Counts the cycles, up to lim, that the output stays at lvl.
  task automatic run_len(input logic lvl, input int lim);
    n = 0;
    while (n < lim && output_enable === lvl)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask : run_len
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input bit last);
    uv_host_i.access(w, c, d, last, rd, er, ok);
    chk_flag("answer", 1'b1, ok);
  endtask : xfer
  // Output off, load an action, then on again at a good level.
  task automatic prep(input logic [7:0] act);
    on_command = 1'b0;
    vout_level = 16'h8000;
    cyc(3);
    xfer(1'b1, 8'h45, {8'h00, act}, 1'b1);
    on_command = 1'b1;
    cyc(4);
    chk_flag("output up", 1'b1, output_enable);
  endtask : prep
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    xfer(1'b0, 8'h43, 16'h0000, 1'b1);
    chk_val("warn reset", 16'h0000, rd);
    xfer(1'b0, 8'h44, 16'h0000, 1'b1);
    chk_val("fault reset", 16'h0000, rd);
    xfer(1'b0, 8'h45, 16'h0000, 1'b1);
    chk_val("action reset", 16'h0080, rd);
    xfer(1'b1, 8'h44, 16'hA5C3, 1'b0);
    xfer(1'b0, 8'h44, 16'h0000, 1'b1);
    chk_val("fault limit", 16'hA5C3, rd);
    xfer(1'b1, 8'h43, 16'h6000, 1'b1);
    xfer(1'b0, 8'h43, 16'h0000, 1'b1);
    chk_val("warn limit", 16'h6000, rd);
    xfer(1'b1, 8'h45, 16'hAB3F, 1'b0);
    xfer(1'b0, 8'h45, 16'h0000, 1'b1);
    chk_val("action", 16'h003F, rd);
    xfer(1'b1, 8'h46, 16'h1234, 1'b1);
    chk_flag("unknown error", 1'b1, er);
    chk_val("unknown data", 16'h0000, rd);
    xfer(1'b1, 8'h44, 16'h4000, 1'b1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_modes;
    prep(8'h00);
    vout_level = 16'h5000;
    cyc(3);
    chk_flag("warning", 1'b1, low_warning_status);
    chk_flag("no fault", 1'b0, low_fault_status);
    vout_level = 16'h3000;
    run_len(1'b1, 40);
    chk_time("ignore on", 40, n, 0);
    chk_flag("fault", 1'b1, low_fault_status);
    prep(8'hC0);
    vout_level = 16'h3000;
    cyc(3);
    run_len(1'b0, 20);
    chk_time("hold off", 20, n, 0);
    vout_level = 16'h8000;
    cyc(3);
    chk_flag("hold resumes", 1'b1, output_enable);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_latch;
    for (int b = 0; b < 2; b++)
    begin
      prep(8'h80);
      vout_level = 16'h3000;
      cyc(3);
      vout_level = 16'h8000;
      run_len(1'b0, 40);
      chk_time("latched off", 40, n, 0);
      uv_host_i.pulse(b[0]);
      cyc(3);
      chk_flag("cleared on", 1'b1, output_enable);
      chk_flag("status cleared", 1'b0, low_fault_status);
    end
    $display("t_latch done");
  endtask : t_latch
  task automatic t_retry;
    unit_cycles = 16'h0004;
    for (int k = 1; k < 7; k++)
    begin
      prep(8'(8'h82 | (k << 3)));
      vout_level = 16'h3000;
      run_len(1'b1, 5);
      run_len(1'b0, 100);
      chk_time("retry gap", 8, n, 3);
      run_len(1'b1, 200);
      chk_time("retry on", 8 * k, n, 3);
      run_len(1'b0, 40);
      chk_time("retry latched", 40, n, 0);
    end
    $display("t_retry done");
  endtask : t_retry
  task automatic t_delay;
    unit_cycles = 16'h0002;
    for (int c = 0; c < 8; c++)
    begin
      prep(8'(8'h40 | c));
      vout_level = 16'h3000;
      run_len(1'b1, 600);
      chk_time("delay on", 2 * units[c], n, 3);
      run_len(1'b0, 20);
      chk_time("delay latched", 20, n, 0);
    end
    prep(8'h45);
    vout_level = 16'h3000;
    cyc(10);
    vout_level = 16'h8000;
    run_len(1'b1, 150);
    chk_time("delay recovers", 150, n, 0);
    $display("t_delay done");
  endtask : t_delay
  task automatic t_forever;
    unit_cycles = 16'h0002;
    for (int s = 0; s < 3; s++)
    begin
      prep(8'hBA);
      vout_level = 16'h3000;
      run_len(1'b1, 5);
      run_len(1'b0, 20);
      chk_time("forever gap", 4, n, 3);
      run_len(1'b1, 60);
      chk_time("forever on", 60, n, 0);
      if (s == 0)
        on_command = 1'b0;
      else if (s == 1)
        bias_ok = 1'b0;
      else
        other_fault_off = 1'b1;
      cyc(3);
      chk_flag("stopped", 1'b0, output_enable);
      bias_ok = 1'b1;
      other_fault_off = 1'b0;
    end
    $display("t_forever done");
  endtask : t_forever
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d, n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Main sequence: reset for 8 cycles, then each scenario.
  initial
  begin
    reset_n = 1'b0;
    vout_level = 16'h8000;
    unit_cycles = 16'h0002;
    on_command = 1'b0;
    bias_ok = 1'b1;
    other_fault_off = 1'b0;
    cyc(8);
    reset_n = 1'b1;
    t_regs();
    t_modes();
    t_latch();
    t_retry();
    t_delay();
    t_forever();
    conclude();
  end
endmodule : test_output_low_supervisor
`default_nettype wire

// ===== testbench/uv_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the supervisor ports: command answers and fault actions.
module uv_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Command port.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_error,
  // Supply side and clears.
  input wire logic [15:0] vout_level,
  input wire logic [15:0] unit_cycles,
  input wire logic on_command,
  input wire logic bias_ok,
  input wire logic other_fault_off,
  input wire logic clear_faults,
  input wire logic clear_low_fault_bit,
  // Output control and status.
  input wire logic output_enable,
  input wire logic low_warning_status,
  input wire logic low_fault_status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] lim_reg; // Shadow of the fault limit.
  logic [15:0] lim_next;
  logic [7:0] act_reg; // Shadow of the action byte.
  logic [7:0] act_next;
  logic known; // Code is one of the three.
  logic fault; // Output on and below the fault limit.
  logic run_ok; // Output is commanded on, bias is good and no other fault forces it off.
  // Shadows follow the writes seen on the port.
  always_comb
  begin
    lim_next = lim_reg;
    act_next = act_reg;
    if (cmd_valid && cmd_write && cmd_code == uv_pkg::CMD_FAULT_LIMIT)
      lim_next = cmd_wdata;
    if (cmd_valid && cmd_write && cmd_code == uv_pkg::CMD_FAULT_ACTION)
      act_next = cmd_wdata[7:0];
    known = cmd_code inside {uv_pkg::CMD_WARN_LIMIT, uv_pkg::CMD_FAULT_LIMIT, uv_pkg::CMD_FAULT_ACTION};
    fault = output_enable && (vout_level < lim_reg);
    run_ok = on_command && bias_ok && !other_fault_off;
  end
  // Registers the shadows.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lim_reg <= uv_pkg::FAULT_LIMIT_RESET;
      act_reg <= uv_pkg::FAULT_ACTION_RESET;
    end
    else
    begin
      lim_reg <= lim_next;
      act_reg <= act_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_cmd_answer: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer after command");
  a_unknown_refused: assert property (cmd_valid && !known |=> rsp_error && rsp_data == 16'h0000)
    else $error("unknown code not refused");
  a_word_readback: assert property (cmd_valid && cmd_write && cmd_code == uv_pkg::CMD_FAULT_LIMIT ##1
    cmd_valid && !cmd_write && cmd_code == uv_pkg::CMD_FAULT_LIMIT |=> rsp_data == $past(cmd_wdata, 2))
    else $error("fault limit readback wrong");
  a_byte_upper: assert property (cmd_valid && !cmd_write && cmd_code == uv_pkg::CMD_FAULT_ACTION |=>
    rsp_data[15:8] == 8'h00) else $error("action byte upper bits set");
  a_ignore_runs: assert property (act_reg[7:6] == uv_pkg::RESP_IGNORE && output_enable && run_ok
    |=> output_enable) else $error("ignore mode dropped output");
  a_hold_off: assert property (act_reg[7:6] == uv_pkg::RESP_HOLD && fault |-> ##[1:2] !output_enable)
    else $error("hold mode kept output on");
  a_shut_fast: assert property (act_reg[7:6] == uv_pkg::RESP_SHUTDOWN && fault && !low_fault_status
    |-> ##[1:2] !output_enable) else $error("shutdown mode kept output on");
  a_delay_keeps: assert property (act_reg[7:6] == uv_pkg::RESP_DELAYED && fault && !low_fault_status
    && run_ok |=> output_enable) else $error("delayed mode dropped output at once");
  a_stop_off: assert property (!run_ok |-> ##[1:2] !output_enable)
    else $error("output on while stopped");
  a_fault_status: assert property (fault |=> low_fault_status)
    else $error("fault status not set");
  // Main scenarios.
  cover property (cmd_valid && !known);
  cover property ($fell(output_enable));
  cover property ($rose(low_fault_status));
endmodule : uv_checker
bind output_low_supervisor uv_checker uv_checker_i (.*);
`default_nettype wire

// ===== testbench/uv_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host that issues commands and clear requests to the supervisor.
module uv_host (
  // Clock.
  input wire logic sys_clk,
  // Command port.
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_error,
  // Clear requests.
  output logic clear_faults,
  output logic clear_low_fault_bit
);
  // Idle from time zero.
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    clear_faults = 1'b0;
    clear_low_fault_bit = 1'b0;
  end
  // One command from a falling edge; the answer is read at the next falling edge.
  // With last low the strobe stays up for a back-to-back command.
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d, input bit last,
    output logic [15:0] rd, output logic er, output logic ok);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge sys_clk);
    @(negedge sys_clk);
    if (last)
    begin
      // Released lines show the inverse of the last value.
      cmd_valid = 1'b0;
      cmd_write = ~w;
      cmd_code = ~c;
      cmd_wdata = ~d;
    end
    rd = rsp_data;
    er = rsp_error;
    ok = rsp_valid;
  endtask : access
  // One-cycle clear request, entered at a falling edge.
  task automatic pulse(input bit bit_clear);
    if (bit_clear)
      clear_low_fault_bit = 1'b1;
    else
      clear_faults = 1'b1;
    @(negedge sys_clk);
    clear_faults = 1'b0;
    clear_low_fault_bit = 1'b0;
  endtask : pulse
endmodule : uv_host
`default_nettype wire
